/* pkg/gx_pkg.sv */
// shared offsets, reset values and field positions of the port expander
package gx_pkg;

    // register byte offsets on the AXI4-Lite bus
    localparam logic [7:0] OFF_INPUT      = 8'h00;
    localparam logic [7:0] OFF_OUTPUT     = 8'h04;
    localparam logic [7:0] OFF_POLARITY   = 8'h08;
    localparam logic [7:0] OFF_CONFIG     = 8'h0C;
    localparam logic [7:0] OFF_IRQ_STATUS = 8'h10;
    localparam logic [7:0] OFF_IRQ_CLEAR  = 8'h14;
    localparam logic [7:0] OFF_IRQ_ENABLE = 8'h18;
    localparam logic [7:0] OFF_TARGET     = 8'h1C;

    // reset values
    localparam logic [7:0] RST_OUTPUT     = 8'hFF;
    localparam logic [7:0] RST_POLARITY   = 8'h00;
    localparam logic [7:0] RST_CONFIG     = 8'hFF;
    localparam logic [7:0] RST_IRQ_ENABLE = 8'h00;
    localparam logic [7:0] RST_IRQ_STATUS = 8'h00;
    localparam logic [2:0] RST_STRAPS     = 3'h0;

    // target address register layout
    localparam int TARGET_STRAP_LSB = 0;
    localparam int TARGET_FIXED_LSB = 3;
    localparam int TARGET_WIRE_BIT  = 8;

    // AXI response codes
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // register select decoded from the bus address
    typedef enum logic [2:0] {
        GX_SEL_INPUT,
        GX_SEL_OUTPUT,
        GX_SEL_POLARITY,
        GX_SEL_CONFIG,
        GX_SEL_IRQ_STATUS,
        GX_SEL_IRQ_CLEAR,
        GX_SEL_IRQ_ENABLE,
        GX_SEL_TARGET
    } gx_sel_t;

endpackage : gx_pkg

/* hdl/gx_pin_bank.sv */
// per-pin drive, pull-up select, input capture and change detection
`timescale 1ns/1ps
module gx_pin_bank #(
    parameter int W = 8
) (
    input  wire logic         aclk,
    input  wire logic         aresetn,
    input  wire logic [W-1:0] cfg_input,
    input  wire logic [W-1:0] out_val,
    input  wire logic         capture,
    input  wire logic [W-1:0] pin_in,
    output logic      [W-1:0] pin_out,
    output logic      [W-1:0] pin_oe_n,
    output logic      [W-1:0] pin_pullup_en,
    output logic      [W-1:0] captured,
    output logic      [W-1:0] mismatch,
    output logic              primed
);

    // first cycle after reset loads the live levels so no false change fires
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            primed <= 1'b0;
        end else begin
            primed <= 1'b1;
        end
    end

    wire load = capture | ~primed;

    for (genvar i = 0; i < W; i++) begin : g_pin
        always_ff @(posedge aclk) begin
            if (!aresetn) begin
                captured[i] <= 1'b0;
            end else if (load) begin
                captured[i] <= pin_in[i];
            end
        end
        assign pin_out[i]       = out_val[i];
        assign pin_oe_n[i]      = cfg_input[i];
        assign pin_pullup_en[i] = cfg_input[i];
        assign mismatch[i]      = primed & cfg_input[i] & (pin_in[i] ^ captured[i]);
    end

endmodule : gx_pin_bank

/* hdl/gx_irq.sv */
// sticky change status, enable mask and level interrupt
`timescale 1ns/1ps
module gx_irq #(
    parameter int W = 8
) (
    input  wire logic         aclk,
    input  wire logic         aresetn,
    input  wire logic [W-1:0] change,
    input  wire logic         clr_we,
    input  wire logic         en_we,
    input  wire logic [W-1:0] wdata,
    output logic      [W-1:0] status,
    output logic      [W-1:0] enable,
    output logic              irq
);

    logic [W-1:0] change_q;
    wire  [W-1:0] rise       = change & ~change_q;
    wire  [W-1:0] clr_mask   = clr_we ? wdata : '0;
    // a new event in the clearing cycle survives the clear
    wire  [W-1:0] next_status = (status & ~clr_mask) | rise;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            change_q <= '0;
            status   <= W'(gx_pkg::RST_IRQ_STATUS);
            enable   <= W'(gx_pkg::RST_IRQ_ENABLE);
        end else begin
            change_q <= change;
            status   <= next_status;
            if (en_we) begin
                enable <= wdata;
            end
        end
    end

    assign irq = |(status & enable);

endmodule : gx_irq

/* hdl/gx_expander.sv */
// 8-bit port expander core with AXI4-Lite register access
//
// What this block does
// - reset leaves every pin input with pull-up
// - direction register selects input or output per pin
// - input and output port registers, bit per pin
// - polarity bits invert returned input values
// - every register except the interrupt clear is readable by master; a read of the clear returns zero
// - reset restores defaults and bus state
// - interrupt when input differs from captured state
// - interrupt pin active low, open drain
// - target address from fixed part plus straps
// - output pins hold latched values until rewritten
`timescale 1ns/1ps
module gx_expander #(
    parameter int         W          = 8,
    parameter int         ADDR_W     = 8,
    // fixed part of the target address; value is arbitrary
    parameter logic [3:0] FIXED_ADDR = 4'h5
) (
    input  wire logic              aclk,
    input  wire logic              aresetn,
    input  wire logic [ADDR_W-1:0] awaddr,
    input  wire logic [2:0]        awprot,
    input  wire logic              awvalid,
    output logic                   awready,
    input  wire logic [31:0]       wdata,
    input  wire logic [3:0]        wstrb,
    input  wire logic              wvalid,
    output logic                   wready,
    output logic      [1:0]        bresp,
    output logic                   bvalid,
    input  wire logic              bready,
    input  wire logic [ADDR_W-1:0] araddr,
    input  wire logic [2:0]        arprot,
    input  wire logic              arvalid,
    output logic                   arready,
    output logic      [31:0]       rdata,
    output logic      [1:0]        rresp,
    output logic                   rvalid,
    input  wire logic              rready,
    input  wire logic              addr_strap_0,
    input  wire logic              addr_strap_1,
    input  wire logic              addr_strap_2,
    input  wire logic [W-1:0]      port_pin_in,
    output logic      [W-1:0]      port_pin_out,
    output logic      [W-1:0]      port_pin_oe_n,
    output logic      [W-1:0]      port_pin_pullup_en,
    input  wire logic              int_n_in,
    output logic                   int_n_out,
    output logic                   int_n_oe_n,
    output logic                   irq
);

    // ---------------------------------------------------------------
    // register state
    // ---------------------------------------------------------------
    logic [W-1:0] out_reg;
    logic [W-1:0] pol_reg;
    logic [W-1:0] cfg_reg;
    logic [2:0]   strap_reg;
    logic         strap_taken;

    logic [W-1:0] captured;
    logic [W-1:0] mismatch;
    logic         primed;
    logic [W-1:0] irq_status;
    logic [W-1:0] irq_enable;

    // protection bits carry no meaning here
    wire unused_prot = ^{awprot, arprot};

    // ---------------------------------------------------------------
    // address decode shared by both channels
    // ---------------------------------------------------------------
    function automatic logic decode_hit(input logic [ADDR_W-1:0] addr,
                                        input logic [7:0]        off);
        logic [7:0] word;
        word = {addr[7:2], 2'h0};
        return word == off;
    endfunction : decode_hit

    function automatic gx_pkg::gx_sel_t decode_sel(input logic [ADDR_W-1:0] addr);
        gx_pkg::gx_sel_t sel;
        sel = gx_pkg::GX_SEL_INPUT;
        if (decode_hit(addr, gx_pkg::OFF_OUTPUT))     sel = gx_pkg::GX_SEL_OUTPUT;
        if (decode_hit(addr, gx_pkg::OFF_POLARITY))   sel = gx_pkg::GX_SEL_POLARITY;
        if (decode_hit(addr, gx_pkg::OFF_CONFIG))     sel = gx_pkg::GX_SEL_CONFIG;
        if (decode_hit(addr, gx_pkg::OFF_IRQ_STATUS)) sel = gx_pkg::GX_SEL_IRQ_STATUS;
        if (decode_hit(addr, gx_pkg::OFF_IRQ_CLEAR))  sel = gx_pkg::GX_SEL_IRQ_CLEAR;
        if (decode_hit(addr, gx_pkg::OFF_IRQ_ENABLE)) sel = gx_pkg::GX_SEL_IRQ_ENABLE;
        if (decode_hit(addr, gx_pkg::OFF_TARGET))     sel = gx_pkg::GX_SEL_TARGET;
        return sel;
    endfunction : decode_sel

    function automatic logic decode_mapped(input logic [ADDR_W-1:0] addr);
        return (addr[ADDR_W-1:5] == '0);
    endfunction : decode_mapped

    // ---------------------------------------------------------------
    // write channel: address and data are taken together
    // ---------------------------------------------------------------
    // waiting for both keeps one write in flight and needs no skid storage
    wire              wr_fire   = awvalid & wvalid & ~bvalid;
    wire gx_pkg::gx_sel_t wr_sel = decode_sel(awaddr);
    wire              wr_mapped = decode_mapped(awaddr);
    wire              wr_lane0  = wr_fire & wr_mapped & wstrb[0];
    wire [W-1:0]      wr_byte   = wdata[W-1:0];

    wire wr_output = wr_lane0 & (wr_sel == gx_pkg::GX_SEL_OUTPUT);
    wire wr_pol    = wr_lane0 & (wr_sel == gx_pkg::GX_SEL_POLARITY);
    wire wr_cfg    = wr_lane0 & (wr_sel == gx_pkg::GX_SEL_CONFIG);
    wire wr_iclr   = wr_lane0 & (wr_sel == gx_pkg::GX_SEL_IRQ_CLEAR);
    wire wr_ien    = wr_lane0 & (wr_sel == gx_pkg::GX_SEL_IRQ_ENABLE);

    assign awready = wr_fire;
    assign wready  = wr_fire;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            bvalid <= 1'b0;
            bresp  <= gx_pkg::RESP_OKAY;
        end else if (wr_fire) begin
            bvalid <= 1'b1;
            bresp  <= wr_mapped ? gx_pkg::RESP_OKAY : gx_pkg::RESP_SLVERR;
        end else if (bready) begin
            bvalid <= 1'b0;
        end
    end

    // ---------------------------------------------------------------
    // configuration, output and polarity registers
    // ---------------------------------------------------------------
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cfg_reg <= W'(gx_pkg::RST_CONFIG);
        end else if (wr_cfg) begin
            cfg_reg <= wr_byte;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            out_reg <= W'(gx_pkg::RST_OUTPUT);
        end else if (wr_output) begin
            out_reg <= wr_byte;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pol_reg <= W'(gx_pkg::RST_POLARITY);
        end else if (wr_pol) begin
            pol_reg <= wr_byte;
        end
    end

    // straps are sampled once, on the first edge after reset release
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            strap_taken <= 1'b0;
            strap_reg   <= gx_pkg::RST_STRAPS;
        end else if (!strap_taken) begin
            strap_taken <= 1'b1;
            strap_reg   <= {addr_strap_2, addr_strap_1, addr_strap_0};
        end
    end

    // ---------------------------------------------------------------
    // read channel
    // ---------------------------------------------------------------
    wire                  rd_fire   = arvalid & ~rvalid;
    wire gx_pkg::gx_sel_t rd_sel    = decode_sel(araddr);
    wire                  rd_mapped = decode_mapped(araddr);
    wire                  rd_input  = rd_fire & rd_mapped & (rd_sel == gx_pkg::GX_SEL_INPUT);

    assign arready = ~rvalid;

    // input view: live pin level with polarity applied
    wire [W-1:0] input_view = port_pin_in ^ pol_reg;

    localparam int TGT_HI = gx_pkg::TARGET_FIXED_LSB + 3;
    logic [31:0] target_word;
    always_comb begin
        target_word = '0;
        target_word[TGT_HI:gx_pkg::TARGET_STRAP_LSB] = {FIXED_ADDR, strap_reg};
        target_word[gx_pkg::TARGET_WIRE_BIT]         = int_n_in;
    end

    logic [31:0] rd_word;
    always_comb begin
        rd_word = '0;
        case (rd_sel)
            gx_pkg::GX_SEL_INPUT: begin
                rd_word[W-1:0] = input_view;
            end
            gx_pkg::GX_SEL_OUTPUT: begin
                rd_word[W-1:0] = out_reg;
            end
            gx_pkg::GX_SEL_POLARITY: begin
                rd_word[W-1:0] = pol_reg;
            end
            gx_pkg::GX_SEL_CONFIG: begin
                rd_word[W-1:0] = cfg_reg;
            end
            gx_pkg::GX_SEL_IRQ_STATUS: begin
                rd_word[W-1:0] = irq_status;
            end
            gx_pkg::GX_SEL_IRQ_ENABLE: begin
                rd_word[W-1:0] = irq_enable;
            end
            gx_pkg::GX_SEL_TARGET: begin
                rd_word = target_word;
            end
            default: begin
                rd_word = '0;
            end
        endcase
        if (!rd_mapped) begin
            rd_word = '0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rvalid <= 1'b0;
            rdata  <= '0;
            rresp  <= gx_pkg::RESP_OKAY;
        end else if (rd_fire) begin
            rvalid <= 1'b1;
            rdata  <= rd_word;
            rresp  <= rd_mapped ? gx_pkg::RESP_OKAY : gx_pkg::RESP_SLVERR;
        end else if (rready) begin
            rvalid <= 1'b0;
        end
    end

    // ---------------------------------------------------------------
    // pins and change detection
    // ---------------------------------------------------------------
    gx_pin_bank #(
        .W (W)
    ) u_pins (
        .aclk          (aclk),
        .aresetn       (aresetn),
        .cfg_input     (cfg_reg),
        .out_val       (out_reg),
        .capture       (rd_input),
        .pin_in        (port_pin_in),
        .pin_out       (port_pin_out),
        .pin_oe_n      (port_pin_oe_n),
        .pin_pullup_en (port_pin_pullup_en),
        .captured      (captured),
        .mismatch      (mismatch),
        .primed        (primed)
    );

    // ---------------------------------------------------------------
    // interrupts
    // ---------------------------------------------------------------
    // open-drain pin follows the live mismatch, so it releases when inputs
    // return or the input register is read; the sticky copy is for software
    assign int_n_out  = 1'b0;
    assign int_n_oe_n = ~(|mismatch) | unused_prot & 1'b0;

    gx_irq #(
        .W (W)
    ) u_irq (
        .aclk    (aclk),
        .aresetn (aresetn),
        .change  (mismatch),
        .clr_we  (wr_iclr),
        .en_we   (wr_ien),
        .wdata   (wr_byte),
        .status  (irq_status),
        .enable  (irq_enable),
        .irq     (irq)
    );

endmodule : gx_expander

/* test/gx_expander_monitor.sv */
// port checker for the expander, bound into its top
`timescale 1ns/1ps
module gx_expander_monitor #(
    parameter int W      = 8,
    parameter int ADDR_W = 8
) (
    input wire logic              aclk,
    input wire logic              aresetn,
    input wire logic [ADDR_W-1:0] awaddr,
    input wire logic              awvalid,
    input wire logic              awready,
    input wire logic [1:0]        bresp,
    input wire logic              bvalid,
    input wire logic              bready,
    input wire logic [ADDR_W-1:0] araddr,
    input wire logic              arvalid,
    input wire logic              arready,
    input wire logic [31:0]       rdata,
    input wire logic [1:0]        rresp,
    input wire logic              rvalid,
    input wire logic              rready,
    input wire logic [W-1:0]      port_pin_in,
    input wire logic [W-1:0]      port_pin_out,
    input wire logic [W-1:0]      port_pin_oe_n,
    input wire logic [W-1:0]      port_pin_pullup_en,
    input wire logic              int_n_oe_n
);
    logic         primed;
    logic [W-1:0] snap;
    wire          wr_take = awvalid && awready;
    wire          rd_take = arvalid && arready;
    wire          wr_out  = wr_take && awaddr[ADDR_W-1:2] == gx_pkg::OFF_OUTPUT[ADDR_W-1:2];
    wire          wr_cfg  = wr_take && awaddr[ADDR_W-1:2] == gx_pkg::OFF_CONFIG[ADDR_W-1:2];
    wire          rd_in   = rd_take && araddr[ADDR_W-1:2] == gx_pkg::OFF_INPUT[ADDR_W-1:2];
    wire          rd_bad  = rd_take && araddr[ADDR_W-1:5] != '0;
    // own copy of the capture, so a stale or missing snapshot shows on the pin
    wire          diff    = primed && |((port_pin_in ^ snap) & port_pin_oe_n);
    always_ff @(posedge aclk) begin
        primed <= aresetn;
    end
    always_ff @(posedge aclk) begin
        if (!primed || rd_in) begin
            snap <= port_pin_in;
        end
    end
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);
    property p_reset; $rose(aresetn) |-> port_pin_oe_n == '1 && port_pin_out == '1 && !bvalid && !rvalid; endproperty
    a_reset: assert property (p_reset) else $error("pins not idle after reset");
    property p_pull; port_pin_pullup_en == port_pin_oe_n; endproperty
    a_pull: assert property (p_pull) else $error("pull-up not on input pin");
    property p_dir; $changed(port_pin_oe_n) |-> $past(wr_cfg); endproperty
    a_dir: assert property (p_dir) else $error("direction moved unwritten");
    property p_out; $changed(port_pin_out) |-> $past(wr_out); endproperty
    a_out: assert property (p_out) else $error("output moved unwritten");
    property p_int; int_n_oe_n == !diff; endproperty
    a_int: assert property (p_int) else $error("interrupt pin wrong");
    property p_wr; wr_take |=> bvalid; endproperty
    a_wr: assert property (p_wr) else $error("write response late");
    property p_bhold; bvalid && !bready |=> bvalid && $stable(bresp); endproperty
    a_bhold: assert property (p_bhold) else $error("write response dropped");
    property p_rhold; rvalid && !rready |=> rvalid && $stable(rdata); endproperty
    a_rhold: assert property (p_rhold) else $error("read data dropped");
    property p_bad; rd_bad |=> rvalid && rresp == gx_pkg::RESP_SLVERR && rdata == '0; endproperty
    a_bad: assert property (p_bad) else $error("unmapped read not refused");
endmodule : gx_expander_monitor

bind gx_expander gx_expander_monitor #(.W(W), .ADDR_W(ADDR_W)) gx_expander_monitor_inst (
    .aclk, .aresetn, .awaddr, .awvalid, .awready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready,
    .rdata, .rresp, .rvalid, .rready, .port_pin_in, .port_pin_out, .port_pin_oe_n, .port_pin_pullup_en,
    .int_n_oe_n
);

/* test/gx_pin_partner.sv */
// pin-side model: outside drivers, pull-ups and the shared interrupt wire
`timescale 1ns/1ps
module gx_pin_partner #(
    parameter int W = 8
) (
    input  wire logic         aclk,
    input  wire logic [W-1:0] port_pin_out,
    input  wire logic [W-1:0] port_pin_oe_n,
    input  wire logic [W-1:0] port_pin_pullup_en,
    input  wire logic [W-1:0] ext_val,
    input  wire logic [W-1:0] ext_en,
    input  wire logic         int_n_out,
    input  wire logic         int_n_oe_n,
    output logic      [W-1:0] port_pin_in,
    output logic              int_n_wire
);
    logic [W-1:0] last_lvl;
    always_ff @(posedge aclk) begin
        last_lvl <= port_pin_in;
    end
    // a floating pin without pull-up wanders instead of holding its last level
    assign port_pin_in = (~port_pin_oe_n & port_pin_out) | (port_pin_oe_n & ext_en & ext_val)
                       | (port_pin_oe_n & ~ext_en & (port_pin_pullup_en | ~last_lvl));
    assign int_n_wire  = int_n_oe_n ? 1'b1 : int_n_out;
endmodule : gx_pin_partner

/* test/tb_gx_expander.sv */
// self-checking bench: bus driver, read and response scoreboard, pin checks
`timescale 1ns/1ps
module tb_gx_expander;
    localparam logic [3:0] FA = 4'hA; // fixed address part; value is arbitrary
    localparam logic [1:0] OK = gx_pkg::RESP_OKAY;
    logic        aclk = 1'b0, aresetn = 1'b0, awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
    logic        arvalid = 1'b0, rready = 1'b0;
    logic        awready, wready, bvalid, arready, rvalid, int_n_out, int_n_oe_n, irq, int_n_wire;
    logic [7:0]  awaddr = 8'h00, araddr = 8'h00, ext_val = 8'h00, ext_en = 8'h00, cfg, ov, pol;
    logic [7:0]  port_pin_in, port_pin_out, port_pin_oe_n, port_pin_pullup_en;
    logic [31:0] wdata = 32'h0, rdata, seed;
    logic [3:0]  wstrb = 4'hF;
    logic [2:0]  straps = 3'h0;
    logic [1:0]  bresp, rresp;
    logic [33:0] rq[$];
    logic [1:0]  bq[$];
    int          bad_count = 0, cmp_count = 0, cyc = 0;
    always #2 aclk = ~aclk;
    gx_expander #(.FIXED_ADDR(FA)) gx_expander_inst (
        .aclk, .aresetn, .awaddr, .awprot(3'h0), .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready,
        .bresp, .bvalid, .bready, .araddr, .arprot(3'h0), .arvalid, .arready, .rdata, .rresp, .rvalid, .rready,
        .addr_strap_0(straps[0]), .addr_strap_1(straps[1]), .addr_strap_2(straps[2]), .port_pin_in,
        .port_pin_out, .port_pin_oe_n, .port_pin_pullup_en, .int_n_in(int_n_wire), .int_n_out, .int_n_oe_n, .irq
    );
    gx_pin_partner gx_pin_partner_inst (
        .aclk, .port_pin_out, .port_pin_oe_n, .port_pin_pullup_en, .ext_val, .ext_en, .int_n_out, .int_n_oe_n,
        .port_pin_in, .int_n_wire
    );
    task automatic results();
        $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
        if (bad_count == 0 && cmp_count > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : results
    task automatic chk(input logic [33:0] got, input logic [33:0] exp);
        cmp_count++;
        if (got !== exp) begin
            bad_count++;
            $display("mismatch at %0t: got %h want %h", $time, got, exp);
        end
    endtask : chk
    task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
        chk({26'h0, got}, {26'h0, exp});
    endtask : chk8
    // ready is sometimes held back so the slave must keep its answer standing
    task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [1:0] er);
        bq.push_back(er);
        @(posedge aclk);
        awaddr <= a;
        wdata <= {24'($random(seed)), d};
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'($random(seed));
        do @(posedge aclk); while (!(awready && wready));
        awvalid <= 1'b0;
        wvalid <= 1'b0;
        do @(posedge aclk); while (!bvalid);
        if (!bready) begin
            bready <= 1'b1;
            @(posedge aclk);
        end
        bready <= 1'b0;
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [8:0] ed, input logic [1:0] er);
        rq.push_back({er, 23'h0, ed});
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'($random(seed));
        do @(posedge aclk); while (!arready);
        arvalid <= 1'b0;
        do @(posedge aclk); while (!rvalid);
        if (!rready) begin
            rready <= 1'b1;
            @(posedge aclk);
        end
        rready <= 1'b0;
    endtask : rd
    function automatic logic [8:0] exp_in();
        return {1'b0, ((ov & ~cfg) | (ext_val & cfg)) ^ pol};
    endfunction : exp_in
    task automatic defaults();
        chk8(port_pin_oe_n, gx_pkg::RST_CONFIG);
        chk8(port_pin_pullup_en, 8'hFF);
        chk8(port_pin_out, gx_pkg::RST_OUTPUT);
        rd(gx_pkg::OFF_INPUT, 9'h0FF, OK);
        rd(gx_pkg::OFF_OUTPUT, {1'b0, gx_pkg::RST_OUTPUT}, OK);
        rd(gx_pkg::OFF_POLARITY, {1'b0, gx_pkg::RST_POLARITY}, OK);
        rd(gx_pkg::OFF_CONFIG, {1'b0, gx_pkg::RST_CONFIG}, OK);
        rd(gx_pkg::OFF_IRQ_STATUS, {1'b0, gx_pkg::RST_IRQ_STATUS}, OK);
        rd(gx_pkg::OFF_IRQ_CLEAR, 9'h000, OK);
        rd(gx_pkg::OFF_IRQ_ENABLE, {1'b0, gx_pkg::RST_IRQ_ENABLE}, OK);
        rd(gx_pkg::OFF_TARGET, {1'b1, 1'b0, FA, straps}, OK);
    endtask : defaults
    always @(posedge aclk) begin
        cyc <= cyc + 1;
        if (rvalid && rready && rq.size() > 0) chk({rresp, rdata}, rq.pop_front());
        if (bvalid && bready && bq.size() > 0) chk({32'h0, bresp}, {32'h0, bq.pop_front()});
        if (cyc == 5000) begin
            bad_count++;
            $display("mismatch at %0t: timeout", $time);
            results();
        end
    end
    initial begin
        seed = 32'hA270;
        straps = 3'($random(seed));
        repeat (12) @(posedge aclk);
        aresetn <= 1'b1;
        @(negedge aclk);
        defaults();
        ext_en <= 8'hFF;
        for (int k = 0; k < 4; k++) begin
            cfg = 8'($random(seed));
            ov = 8'($random(seed));
            pol = 8'($random(seed));
            ext_val <= 8'($random(seed));
            wr(gx_pkg::OFF_OUTPUT, ov, OK);
            wr(gx_pkg::OFF_CONFIG, cfg, OK);
            wr(gx_pkg::OFF_POLARITY, pol, OK);
            @(negedge aclk);
            chk8(port_pin_oe_n, cfg);
            chk8(port_pin_out, ov);
            rd(gx_pkg::OFF_INPUT, exp_in(), OK);
            rd(gx_pkg::OFF_CONFIG, {1'b0, cfg}, OK);
            rd(gx_pkg::OFF_POLARITY, {1'b0, pol}, OK);
        end
        wstrb <= 4'hE;
        wr(gx_pkg::OFF_OUTPUT, ~ov, OK);
        wstrb <= 4'hF;
        rd(gx_pkg::OFF_OUTPUT, {1'b0, ov}, OK);
        wr(gx_pkg::OFF_INPUT, 8'h00, OK);
        rd(8'h20, 9'h000, gx_pkg::RESP_SLVERR);
        wr(8'h20, 8'hA5, gx_pkg::RESP_SLVERR);
        cfg = 8'hF0;
        wr(gx_pkg::OFF_CONFIG, cfg, OK);
        rd(gx_pkg::OFF_INPUT, exp_in(), OK);
        wr(gx_pkg::OFF_IRQ_CLEAR, 8'hFF, OK);
        wr(gx_pkg::OFF_IRQ_ENABLE, 8'h10, OK);
        rd(gx_pkg::OFF_IRQ_STATUS, 9'h000, OK);
        ext_val <= ext_val ^ 8'h11;
        @(negedge aclk);
        @(negedge aclk);
        chk8({int_n_wire, 6'h00, irq}, 8'h01);
        rd(gx_pkg::OFF_IRQ_STATUS, 9'h010, OK);
        rd(gx_pkg::OFF_INPUT, exp_in(), OK);
        @(negedge aclk);
        chk8({int_n_wire, 6'h00, irq}, 8'h81);
        wr(gx_pkg::OFF_IRQ_CLEAR, 8'h10, OK);
        ext_val <= ext_val ^ 8'h40;
        @(negedge aclk);
        @(negedge aclk);
        chk8({int_n_wire, 6'h00, irq}, 8'h00);
        @(posedge aclk);
        ext_val <= ext_val ^ 8'h40;
        @(negedge aclk);
        chk8({int_n_wire, 6'h00, irq}, 8'h80);
        rd(gx_pkg::OFF_IRQ_STATUS, 9'h040, OK);
        @(posedge aclk);
        aresetn <= 1'b0;
        ext_en <= 8'h00;
        repeat (12) @(posedge aclk);
        aresetn <= 1'b1;
        @(negedge aclk);
        defaults();
        results();
    end
endmodule : tb_gx_expander
